// File: hw/bce_core.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "bce_core_regs.svh"

module bce_core (
  input wire logic clk,                       // 40 MHz core clock
  input wire logic rst_b,                     // async reset, active low
  input wire bce_pkg::bce_bus_t bus_i,        // register bus request
  output logic [7:0] bus_rdata,               // read data, cycle after rd
  input wire logic [11:0] instr_in,           // program word at pc_o
  input wire logic [8:0] stack_top,           // return address
  output logic [8:0] pc_o,                    // program counter
  output logic [7:0] w_o,                     // work register
  output logic [7:0] cfg_o,                   // configuration register
  output logic carry_o,                       // carry flag
  output logic zero_o,                        // zero flag
  output logic instr_cycle_o                  // last quarter of a cycle
);

  // decode one instruction word into its fields
  function automatic bce_pkg::bce_dec_t decode(input logic [11:0] iw);
    bce_pkg::bce_dec_t d;
    d.op = bce_pkg::OP_NOP;
    d.dest = iw[5];
    d.fa = iw[4:0];
    d.bidx = iw[7:5];
    d.lit = iw[7:0];
    if (iw[11:8] == `BCE_OPC_BSET) begin
      d.op = bce_pkg::OP_BSET;
    end else if (iw[11:8] == `BCE_OPC_BSS) begin
      d.op = bce_pkg::OP_BSS;
    end else if (iw[11:8] == `BCE_OPC_BSC) begin
      d.op = bce_pkg::OP_BSC;
    end else if (iw[11:8] == `BCE_OPC_LOAD_LITERAL_OP) begin
      d.op = bce_pkg::OP_LOAD_LITERAL_OP;
    end else if (iw[11:8] == `BCE_OPC_RETURN_WITH_LITERAL) begin
      d.op = bce_pkg::OP_RETURN_WITH_LITERAL;
    end else if (iw[11:6] == `BCE_OPC_MOVE_FILE_OP) begin
      d.op = bce_pkg::OP_MOVE_FILE_OP;
    end else if (iw[11:6] == `BCE_OPC_RLF) begin
      d.op = bce_pkg::OP_RLF;
    end else if (iw[11:6] == `BCE_OPC_RRF) begin
      d.op = bce_pkg::OP_RRF;
    end else if (iw[11:5] == `BCE_OPC_STORE_ACCUM_OP) begin
      d.op = bce_pkg::OP_STORE_ACCUM_OP;
    end else if (iw == `BCE_IW_CFG) begin
      d.op = bce_pkg::OP_CFG;
    end
    return d;
  endfunction

  logic rst_m_ff;
  logic rst_sync_b;
  bce_pkg::bce_phase_t phase_ff, nxt_phase_ff;
  logic run_ff, nxt_run_ff;
  logic [11:0] ir_ff, nxt_ir_ff;
  logic flush_ff, nxt_flush_ff;
  logic [8:0] pc_ff, nxt_pc_ff;
  logic [7:0] w_ff, nxt_w_ff;
  logic [7:0] cfg_ff, nxt_cfg_ff;
  logic c_ff, nxt_c_ff;
  logic z_ff, nxt_z_ff;
  logic [7:0] rdata_ff, nxt_rdata_ff;
  logic [7:0] fregs [0:31];
  bce_pkg::bce_dec_t dec;
  logic cyc_end;
  logic exec;
  logic [7:0] fdata;
  logic [7:0] res;
  logic res_wr;
  logic fw_core;
  logic [7:0] fw_core_data;
  logic fw_en;
  logic [4:0] fw_addr;
  logic [7:0] fw_data;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_ff <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_sync_b <= rst_m_ff;
    end
  end

  // quarter phase of the instruction cycle
  // four periods make one cycle
  always_comb begin
    nxt_phase_ff = phase_ff;
    if (run_ff) begin
      case (phase_ff)
        bce_pkg::PH_Q1: nxt_phase_ff = bce_pkg::PH_Q2;
        bce_pkg::PH_Q2: nxt_phase_ff = bce_pkg::PH_Q3;
        bce_pkg::PH_Q3: nxt_phase_ff = bce_pkg::PH_Q4;
        bce_pkg::PH_Q4: nxt_phase_ff = bce_pkg::PH_Q1;
        default: nxt_phase_ff = bce_pkg::PH_Q1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      phase_ff <= bce_pkg::PH_Q1;
    end else begin
      phase_ff <= nxt_phase_ff;
    end
  end

  assign cyc_end = run_ff && (phase_ff == bce_pkg::PH_Q4);
  // a flushed word becomes a no-op cycle
  assign exec = cyc_end && !flush_ff;
  assign dec = decode(ir_ff);
  // 5-bit address selects one of 32
  assign fdata = fregs[dec.fa];

  // execute the held word and fetch the next one
  always_comb begin
    nxt_ir_ff = ir_ff;
    nxt_pc_ff = pc_ff;
    nxt_flush_ff = flush_ff;
    nxt_w_ff = w_ff;
    nxt_cfg_ff = cfg_ff;
    nxt_c_ff = c_ff;
    nxt_z_ff = z_ff;
    res = fdata;
    res_wr = 1'b0;
    fw_core = 1'b0;
    fw_core_data = fdata;
    if (cyc_end) begin
      nxt_ir_ff = instr_in;
      nxt_pc_ff = pc_ff + 9'h001;
      nxt_flush_ff = 1'b0;
    end
    if (exec) begin
      case (dec.op)
        bce_pkg::OP_BSET: begin
          fw_core = 1'b1;
          fw_core_data = fdata | (8'h01 << dec.bidx);
        end
        bce_pkg::OP_BSS: nxt_flush_ff = fdata[dec.bidx];
        bce_pkg::OP_BSC: nxt_flush_ff = !fdata[dec.bidx];
        bce_pkg::OP_MOVE_FILE_OP: begin
          nxt_z_ff = (fdata == 8'h00);
          res_wr = 1'b1;
        end
        bce_pkg::OP_STORE_ACCUM_OP: begin
          fw_core = 1'b1;
          fw_core_data = w_ff;
        end
        bce_pkg::OP_LOAD_LITERAL_OP: nxt_w_ff = dec.lit;
        bce_pkg::OP_CFG: nxt_cfg_ff = w_ff;
        bce_pkg::OP_RETURN_WITH_LITERAL: begin
          nxt_w_ff = dec.lit;
          nxt_pc_ff = stack_top;
          nxt_flush_ff = 1'b1;
        end
        bce_pkg::OP_RLF: begin
          nxt_c_ff = fdata[7];
          res = {fdata[6:0], c_ff};
          res_wr = 1'b1;
        end
        bce_pkg::OP_RRF: begin
          nxt_c_ff = fdata[0];
          res = {c_ff, fdata[7:1]};
          res_wr = 1'b1;
        end
        // all-zero word and unknown words do nothing
        default: nxt_flush_ff = 1'b0;
      endcase
      if (res_wr && dec.dest) begin
        fw_core = 1'b1;
        fw_core_data = res;
      end else if (res_wr) begin
        nxt_w_ff = res;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ir_ff <= `BCE_IW_NOP;
      pc_ff <= `BCE_RST_PC;
      flush_ff <= 1'b0;
      w_ff <= 8'h00;
      cfg_ff <= 8'h00;
      c_ff <= 1'b0;
      z_ff <= 1'b0;
    end else begin
      ir_ff <= nxt_ir_ff;
      pc_ff <= nxt_pc_ff;
      flush_ff <= nxt_flush_ff;
      w_ff <= nxt_w_ff;
      cfg_ff <= nxt_cfg_ff;
      c_ff <= nxt_c_ff;
      z_ff <= nxt_z_ff;
    end
  end

  // file write port, core before bus
  always_comb begin
    fw_en = fw_core;
    fw_addr = dec.fa;
    fw_data = fw_core_data;
    if (!fw_core && bus_i.wr && bus_i.addr <= `BCE_A_FREG_TOP) begin
      fw_en = 1'b1;
      fw_addr = bus_i.addr[4:0];
      fw_data = bus_i.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (fw_en) begin
      fregs[fw_addr] <= fw_data;
    end
  end

  // bus control write and read mux
  always_comb begin
    nxt_run_ff = run_ff;
    nxt_rdata_ff = 8'h00;
    if (bus_i.wr && bus_i.addr == `BCE_A_CTRL) begin
      nxt_run_ff = bus_i.wdata[`BCE_RUN_BIT];
    end
    if (bus_i.rd) begin
      if (bus_i.addr <= `BCE_A_FREG_TOP) begin
        nxt_rdata_ff = fregs[bus_i.addr[4:0]];
      end else if (bus_i.addr == `BCE_A_WORK) begin
        nxt_rdata_ff = w_ff;
      end else if (bus_i.addr == `BCE_A_STATUS) begin
        nxt_rdata_ff[`BCE_C_BIT] = c_ff;
        nxt_rdata_ff[`BCE_Z_BIT] = z_ff;
      end else if (bus_i.addr == `BCE_A_CFG) begin
        nxt_rdata_ff = cfg_ff;
      end else if (bus_i.addr == `BCE_A_PCLO) begin
        nxt_rdata_ff = pc_ff[7:0];
      end else if (bus_i.addr == `BCE_A_CTRL) begin
        nxt_rdata_ff[`BCE_RUN_BIT] = run_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      run_ff <= `BCE_RST_RUN;
      rdata_ff <= 8'h00;
    end else begin
      run_ff <= nxt_run_ff;
      rdata_ff <= nxt_rdata_ff;
    end
  end

  // outputs
  assign bus_rdata = rdata_ff;
  assign pc_o = pc_ff;
  assign w_o = w_ff;
  assign cfg_o = cfg_ff;
  assign carry_o = c_ff;
  assign zero_o = z_ff;
  assign instr_cycle_o = cyc_end;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  chk_quarter_len: assert property (
    cyc_end |=> (!cyc_end)[*3]) else $error("cycle shorter than four");
  chk_one_cycle: assert property (
    exec && dec.op != bce_pkg::OP_BSS && dec.op != bce_pkg::OP_BSC &&
    dec.op != bce_pkg::OP_RETURN_WITH_LITERAL |=> !flush_ff)
    else $error("plain instruction flushed");
  chk_skip_taken: assert property (
    exec && ((dec.op == bce_pkg::OP_BSS && fdata[dec.bidx]) ||
    (dec.op == bce_pkg::OP_BSC && !fdata[dec.bidx])) |=> flush_ff)
    else $error("taken skip not flushed");
  chk_bit_set: assert property (
    exec && dec.op == bce_pkg::OP_BSET |=>
    fregs[$past(dec.fa)][$past(dec.bidx)] && $stable(c_ff) && $stable(z_ff))
    else $error("bit not set");
  chk_move_file_op_dest: assert property (
    exec && dec.op == bce_pkg::OP_MOVE_FILE_OP && !dec.dest |=>
    w_ff == $past(fdata) && z_ff == ($past(fdata) == 8'h00))
    else $error("move to work wrong");
  chk_store_accum: assert property (
    exec && dec.op == bce_pkg::OP_STORE_ACCUM_OP |=> fregs[$past(dec.fa)] == w_ff)
    else $error("store to file wrong");
  chk_load_lit: assert property (
    exec && dec.op == bce_pkg::OP_LOAD_LITERAL_OP |=> w_ff == $past(ir_ff[7:0]))
    else $error("literal not loaded");
  chk_load_cfg: assert property (
    exec && dec.op == bce_pkg::OP_CFG |=> cfg_ff == w_ff)
    else $error("config not loaded");
  chk_return_pc: assert property (
    exec && dec.op == bce_pkg::OP_RETURN_WITH_LITERAL |=>
    pc_ff == $past(stack_top) && flush_ff) else $error("return wrong");
  chk_rot_left: assert property (
    exec && dec.op == bce_pkg::OP_RLF |=> c_ff == $past(fdata[7]) &&
    $stable(z_ff)) else $error("left carry wrong");
  chk_rot_right: assert property (
    exec && dec.op == bce_pkg::OP_RRF |=> c_ff == $past(fdata[0]) &&
    $stable(z_ff)) else $error("right carry wrong");
  chk_nop_quiet: assert property (
    exec && ir_ff == `BCE_IW_NOP |=> $stable(w_ff) && $stable(c_ff) &&
    $stable(z_ff) && $stable(cfg_ff) && !flush_ff &&
    pc_ff == $past(pc_ff) + 9'h001) else $error("no-op changed state");

  cov_skip: cover property (exec && dec.op == bce_pkg::OP_BSS ##1 flush_ff);
  cov_ret: cover property (exec && dec.op == bce_pkg::OP_RETURN_WITH_LITERAL);
  cov_rlf_file: cover property (exec && dec.op == bce_pkg::OP_RLF && dec.dest);

endmodule
`default_nettype wire

// File: hw/bce_core_regs.svh
`ifndef BCE_CORE_REGS_SVH
`define BCE_CORE_REGS_SVH
// oscillator period and instruction cycle length in oscillator periods
`define BCE_OSC_NS 25
`define BCE_Q_PER_CYC 4
// register bus map
`define BCE_A_FREG_TOP 6'h1f
`define BCE_A_WORK 6'h20
`define BCE_A_STATUS 6'h21
`define BCE_A_CFG 6'h22
`define BCE_A_PCLO 6'h23
`define BCE_A_CTRL 6'h24
// status and control field positions
`define BCE_C_BIT 0
`define BCE_Z_BIT 1
`define BCE_RUN_BIT 0
// reset values
`define BCE_RST_RUN 1'b1
`define BCE_RST_PC 9'h000
// opcode fields
`define BCE_OPC_BSET 4'h5
`define BCE_OPC_BSS 4'h7
`define BCE_OPC_BSC 4'h6
`define BCE_OPC_LOAD_LITERAL_OP 4'hc
`define BCE_OPC_RETURN_WITH_LITERAL 4'h8
`define BCE_OPC_MOVE_FILE_OP 6'h08
`define BCE_OPC_RLF 6'h0d
`define BCE_OPC_RRF 6'h0c
`define BCE_OPC_STORE_ACCUM_OP 7'h01
`define BCE_IW_NOP 12'h000
`define BCE_IW_CFG 12'h002
`endif

// File: hw/bce_pkg.sv
package bce_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } bce_phase_t;
  typedef enum logic [3:0] {
    OP_NOP, OP_BSET, OP_BSS, OP_BSC, OP_MOVE_FILE_OP, OP_STORE_ACCUM_OP,
    OP_LOAD_LITERAL_OP, OP_CFG, OP_RETURN_WITH_LITERAL, OP_RLF, OP_RRF
  } bce_op_t;
  typedef struct packed {
    bce_op_t op;
    logic dest;
    logic [4:0] fa;
    logic [2:0] bidx;
    logic [7:0] lit;
  } bce_dec_t;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bce_bus_t;
endpackage

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: bus tasks and an instruction feeder drive the core
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bce_pkg::bce_bus_t bus_i = '0;
  logic [11:0] instr_in = 12'h000;
  logic [8:0] stack_top = 9'h155;
  logic [7:0] bus_rdata;
  logic [7:0] w_o;
  logic [7:0] cfg_o;
  logic [8:0] pc_o;
  logic carry_o;
  logic zero_o;
  logic instr_cycle_o;
  int err_total = 0;
  int num_checks = 0;
  int cyc_n;
  logic [8:0] pc_snap;
  logic [11:0] sk_w [4] = '{12'h707, 12'h667, 12'h747, 12'h627};
  logic [7:0] sk_e [4] = '{8'hcc, 8'hcc, 8'h33, 8'h44};

  // 40 mhz clock
  always #12.5 clk = ~clk;

  bce_core bce_core_i (
    .clk(clk),
    .rst_b(rst_b),
    .bus_i(bus_i),
    .bus_rdata(bus_rdata),
    .instr_in(instr_in),
    .stack_top(stack_top),
    .pc_o(pc_o),
    .w_o(w_o),
    .cfg_o(cfg_o),
    .carry_o(carry_o),
    .zero_o(zero_o),
    .instr_cycle_o(instr_cycle_o)
  );

  // compare and count
  task automatic chk(input string name, input logic [11:0] seen,
                     input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle bus write
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_i <= '0;
  endtask

  // one-cycle bus read, data taken in the following cycle
  task automatic chk_rd(input string name, input logic [5:0] a,
                        input logic [7:0] exp);
    @(posedge clk);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_i <= '0;
    #1;
    chk(name, {4'h0, bus_rdata}, {4'h0, exp});
  endtask

  // present a word from one fetch edge to the next
  task automatic issue(input logic [11:0] w);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (instr_cycle_o === 1'b1) break;
    end
    @(posedge clk);
    instr_in <= w;
  endtask

  // two words back to back, then no-ops until both have retired
  task automatic prog(input logic [11:0] w1, input logic [11:0] w2);
    issue(w1);
    issue(w2);
    repeat (3) issue(12'h000);
    #1;
  endtask

  // flag pair as one value: carry high, zero low
  function automatic logic [11:0] flg();
    return {10'h000, carry_o, zero_o};
  endfunction

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("w_rst", {4'h0, w_o}, 12'h000);
    chk("cfg_rst", {4'h0, cfg_o}, 12'h000);
    chk_rd("status_rst", 6'h21, 8'h00);
    $display("test reset done");
    issue(12'h000);
    cyc_n = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      cyc_n++;
      if (instr_cycle_o === 1'b1) break;
    end
    chk("cycle_len", cyc_n[11:0], 12'h004);
    // snapshot after the fetch edge that ends this cycle
    @(posedge clk);
    #1;
    pc_snap = pc_o;
    prog(12'h000, 12'h000);
    chk("pc_step", {3'h0, pc_o}, {3'h0, pc_snap + 9'h005});
    chk("nop_w", {4'h0, w_o}, 12'h000);
    chk("nop_flags", flg(), 12'h000);
    $display("test timing done");
    prog(12'hcff, 12'h000);
    chk("load_literal_op_w", {4'h0, w_o}, 12'h0ff);
    chk("load_literal_op_flags", flg(), 12'h000);
    prog(12'h03f, 12'h000);
    chk_rd("store_accum_op_f31", 6'h1f, 8'hff);
    chk("store_accum_op_flags", flg(), 12'h000);
    prog(12'h002, 12'h000);
    chk("cfg_load", {4'h0, cfg_o}, 12'h0ff);
    chk_rd("cfg_bus", 6'h22, 8'hff);
    bus_wr(6'h05, 8'h0a);
    prog(12'h5e5, 12'h000);
    chk_rd("bset_f5", 6'h05, 8'h8a);
    chk("bset_flags", flg(), 12'h000);
    $display("test literal done");
    prog(12'h205, 12'h000);
    chk("move_file_op_w", {4'h0, w_o}, 12'h08a);
    chk("move_file_op_nz", flg(), 12'h000);
    chk_rd("move_file_op_f5", 6'h05, 8'h8a);
    bus_wr(6'h06, 8'h00);
    prog(12'h226, 12'h000);
    chk("move_file_op_z", flg(), 12'h001);
    chk("move_file_op_keep_w", {4'h0, w_o}, 12'h08a);
    bus_wr(6'h07, 8'he6);
    prog(12'h347, 12'h000);
    chk("rlf_w", {4'h0, w_o}, 12'h0cc);
    chk("rlf_flags", flg(), 12'h003);
    chk_rd("rlf_f7", 6'h07, 8'he6);
    prog(12'h327, 12'h000);
    chk_rd("rrf_f7", 6'h07, 8'hf3);
    chk("rrf_flags", flg(), 12'h001);
    chk("rrf_w", {4'h0, w_o}, 12'h0cc);
    $display("test byte ops done");
    for (int i = 0; i < 4; i++) begin
      prog(sk_w[i], {4'hc, 8'(8'h11 * (i + 1))});
      chk("skip_w", {4'h0, w_o}, {4'h0, sk_e[i]});
      chk("skip_flags", flg(), 12'h001);
    end
    $display("test skip done");
    prog(12'h85a, 12'hc77);
    chk("return_with_literal_w", {4'h0, w_o}, 12'h05a);
    chk("return_with_literal_pc", {3'h0, pc_o}, {3'h0, stack_top + 9'h002});
    $display("test return done");
    bus_wr(6'h20, 8'h00);
    chk_rd("work_ro", 6'h20, 8'h5a);
    // read data stands one cycle only, then returns to zero
    @(posedge clk);
    #1;
    chk("rdata_idle", {4'h0, bus_rdata}, 12'h000);
    chk_rd("unmapped", 6'h30, 8'h00);
    bus_wr(6'h24, 8'h00);
    cyc_n = 0;
    repeat (8) begin
      @(negedge clk);
      if (instr_cycle_o !== 1'b0) cyc_n++;
    end
    chk("halt_pulses", cyc_n[11:0], 12'h000);
    chk_rd("ctrl_off", 6'h24, 8'h00);
    bus_wr(6'h24, 8'h01);
    chk_rd("ctrl_on", 6'h24, 8'h01);
    $display("test bus done");
    results();
  end

  // watchdog well beyond the expected run length
  initial begin
    #(25 * 20000);
    err_total++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
